//--- fdh_device.sv
`timescale 1ns/1ps
// What this block does
// - request pins tri-state unless base mode or gate enabled
// - host reads status before command/result bytes
// - host waits or polls ready after bytes
// - command bytes only when ready, direction in
// - result bytes only when ready, direction out
// - non-DMA execution interrupts per byte, data read or write clears
// - ready bit mirrors interrupt; data read or write clears it
// - host checks status on every interrupt
// - DMA mode requests per byte, acknowledge clears
// - execution end interrupts; first result read clears
// - compatibility mode programmed transfers report abnormal
// - DMA strobes only under acknowledge; select ignored
// - select gates programmed strobes; acknowledge held high
// - all results read before new command accepted
// - status always readable; results only result phase
// - bytes sent and read in prescribed order
// - phases advance automatically after last byte
// - rate register loads two bits, select inactive
// - rate bits select data rate, glitch-free
// - supplied clock glitchless, else reset needed
// - ready within six bit times; busy drops
// - status bit layout: ready, direction, exec, busy
// - acknowledge honoured only in base mode or when gated; count also in non-DMA, non-AT modes
module fdh_device #(
  parameter int RES_MAX = fdh_pkg::RES_MAX
) (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  fdh_bus_if.dev bus,
  input wire fdh_pkg::fdh_mode_t mode_i,
  input wire logic dma_gate_enable_i,
  input wire logic non_dma_i,
  input wire logic fm_i,
  input wire logic drive_speed_select_i,
  input wire logic [3:0] seek_busy_i,
  output logic [7:0] cmd_byte_o,
  output logic cmd_strobe_o,
  input wire logic cmd_done_i,
  input wire logic write_cmd_i,
  input wire logic exec_req_i,
  input wire logic [7:0] exec_rd_data_i,
  input wire logic exec_end_i,
  output logic [7:0] exec_wr_data_o,
  output logic exec_wr_valid_o,
  output logic tc_o,
  input wire logic [RES_MAX*8-1:0] res_data_i,
  input wire logic [2:0] res_count_i,
  output logic [1:0] rate_sel_o,
  output logic bit_tick_o
);
  if (RES_MAX < 1 || RES_MAX > 7) begin : g_chk
    $error("RES_MAX must be 1 to 7");
  end

  typedef enum logic [1:0] {PH_CMD, PH_EXEC, PH_RESULT} fdh_phase_t;
  fdh_phase_t ph_q;
  logic [14:0] s1_q, s2_q;
  logic rd_prev_q, wr_prev_q, acc_data_q, acc_rate_q;
  logic [7:0] wdata_q, xbuf_q, dout_q;
  logic db_oe_q, irq_q, irq_oe_q, drq_q, drq_oe_q;
  logic rqm_q, tmr_on_q, cb_q, idle_pend_q, tc_pend_q;
  logic [3:0] tmr_q;
  logic [2:0] res_idx_q, res_cnt_q;
  logic [RES_MAX*8-1:0] res_buf_q;
  logic [1:0] rate_q;
  logic [8:0] div_q;

  function automatic logic [8:0] div_for(input logic [1:0] r,
                                         input logic fm,
                                         input logic drv);
    logic [8:0] d;
    d = fdh_pkg::DIV_125K;
    case (r)
      2'h0: d = fm ? fdh_pkg::DIV_250K : fdh_pkg::DIV_500K;
      2'h1: d = drv ? fdh_pkg::DIV_300K : fdh_pkg::DIV_250K;
      2'h2: d = fm ? fdh_pkg::DIV_125K : fdh_pkg::DIV_250K;
      default: d = fdh_pkg::DIV_125K;
    endcase
    return d;
  endfunction

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s1_q <= fdh_pkg::SYNC_RESET;
      s2_q <= fdh_pkg::SYNC_RESET;
    end else begin
      s1_q <= {bus.rd_n, bus.wr_n, bus.cs_n, bus.a0, bus.rate_register_load_strobe_n,
               bus.dma_acknowledge_n, bus.tc, bus.db};
      s2_q <= s1_q;
    end
  end

  logic rd_act, wr_act, dma_acknowledge_eff, pio, sel_data, rd_end, wr_end;
  logic data_rd_evt, data_wr_evt, rate_wr_evt, tc_hit, exec_stop;
  logic cmd_evt, res_evt, xfer_evt, last_res, base;
  logic [7:0] main_status, data_val, res_byte;
  assign base = (mode_i == fdh_pkg::FDH_MODE_BASE);
  assign rd_act = !s2_q[14];
  assign wr_act = !s2_q[13];
  assign dma_acknowledge_eff = !s2_q[9] && (base || dma_gate_enable_i);
  assign pio = !s2_q[12] && !dma_acknowledge_eff;
  assign sel_data = dma_acknowledge_eff || (pio && s2_q[11]);
  assign rd_end = rd_prev_q && !rd_act;
  assign wr_end = wr_prev_q && !wr_act;
  assign data_rd_evt = rd_end && acc_data_q;
  assign data_wr_evt = wr_end && acc_data_q;
  assign rate_wr_evt = wr_end && acc_rate_q;
  // terminal count needs acknowledge for DMA; in non-DMA mode it also counts without one, except in AT mode
  assign tc_hit = (ph_q == PH_EXEC) && s2_q[8] && (dma_acknowledge_eff ||
                  (non_dma_i && mode_i != fdh_pkg::FDH_MODE_AT));
  // a count seen with a strobe ends execution once that byte has moved
  assign exec_stop = (ph_q == PH_EXEC) && (exec_end_i ||
                     (tc_pend_q && !rd_act && !wr_act));
  assign cmd_evt = data_wr_evt && ph_q == PH_CMD && rqm_q;
  assign res_evt = data_rd_evt && ph_q == PH_RESULT && rqm_q;
  assign xfer_evt = (ph_q == PH_EXEC) && (write_cmd_i ? data_wr_evt
                                                      : data_rd_evt);
  assign last_res = (res_idx_q + 3'h1 >= res_cnt_q);
  assign res_byte = res_buf_q[res_idx_q*8 +: 8];

  always_comb begin
    main_status = {rqm_q, 1'b0, 1'b0, cb_q, seek_busy_i};
    if (ph_q == PH_EXEC) begin
      main_status[fdh_pkg::MSR_RQM] = non_dma_i && irq_q;
      main_status[fdh_pkg::MSR_DIO] = !write_cmd_i;
      main_status[fdh_pkg::MSR_EXM] = non_dma_i;
    end else if (ph_q == PH_RESULT) begin
      main_status[fdh_pkg::MSR_DIO] = 1'b1;
    end
    data_val = xbuf_q;
    if (ph_q == PH_RESULT) begin
      data_val = res_byte;
      if (res_idx_q == 3'h0 && non_dma_i &&
          mode_i == fdh_pkg::FDH_MODE_AT) begin
        data_val[7:6] = fdh_pkg::ST0_ABNORMAL;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rd_prev_q <= 1'b0;
      wr_prev_q <= 1'b0;
      acc_data_q <= 1'b0;
      acc_rate_q <= 1'b0;
      wdata_q <= 8'h00;
    end else begin
      rd_prev_q <= rd_act;
      wr_prev_q <= wr_act;
      if (rd_act || wr_act) begin
        acc_data_q <= sel_data;
        acc_rate_q <= !s2_q[10] && s2_q[12] && !dma_acknowledge_eff;
      end
      if (wr_act) begin
        wdata_q <= s2_q[7:0];
      end
    end
  end

  // read data is refreshed every clock cycle, so the last sample is live
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      dout_q <= 8'h00;
      db_oe_q <= 1'b0;
    end else begin
      db_oe_q <= rd_act && (dma_acknowledge_eff || pio);
      dout_q <= sel_data ? data_val : main_status;
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ph_q <= PH_CMD;
      res_idx_q <= 3'h0;
      res_cnt_q <= 3'h1;
      res_buf_q <= '0;
      tc_pend_q <= 1'b0;
    end else begin
      case (ph_q)
        PH_CMD: begin
          if (cmd_done_i) begin
            ph_q <= PH_EXEC;
          end
        end
        PH_EXEC: begin
          if (tc_hit) begin
            tc_pend_q <= 1'b1;
          end
          if (exec_stop) begin
            tc_pend_q <= 1'b0;
            ph_q <= PH_RESULT;
            res_idx_q <= 3'h0;
            res_cnt_q <= (res_count_i == 3'h0) ? 3'h1 : res_count_i;
            res_buf_q <= res_data_i;
          end
        end
        default: begin
          if (res_evt) begin
            res_idx_q <= res_idx_q + 3'h1;
            if (last_res) begin
              ph_q <= PH_CMD;
            end
          end
        end
      endcase
    end
  end

  // ready comes back a fixed number of bit times after each command or result byte
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rqm_q <= 1'b1;
      tmr_on_q <= 1'b0;
      tmr_q <= 4'h0;
      cb_q <= 1'b0;
      idle_pend_q <= 1'b0;
    end else begin
      if (cmd_evt || res_evt) begin
        rqm_q <= 1'b0;
        tmr_on_q <= 1'b1;
        tmr_q <= fdh_pkg::READY_BITS;
      end else if (exec_stop) begin
        rqm_q <= 1'b1;
        tmr_on_q <= 1'b0;
      end else if (tmr_on_q && bit_tick_o) begin
        tmr_q <= tmr_q - 4'h1;
        if (tmr_q == 4'h1) begin
          tmr_on_q <= 1'b0;
          rqm_q <= 1'b1;
          if (idle_pend_q) begin
            cb_q <= 1'b0;
          end
        end
      end
      if (cmd_evt) begin
        cb_q <= 1'b1;
        idle_pend_q <= 1'b0;
      end else if (res_evt && last_res) begin
        idle_pend_q <= 1'b1;
      end
    end
  end

  // set wins over a transfer clear in both request flags; execution end clears drq
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      irq_q <= 1'b0;
      drq_q <= 1'b0;
      irq_oe_q <= 1'b0;
      drq_oe_q <= 1'b0;
      xbuf_q <= 8'h00;
    end else begin
      irq_oe_q <= base || dma_gate_enable_i;
      drq_oe_q <= base || dma_gate_enable_i;
      if (exec_stop) begin
        irq_q <= 1'b1;
      end else if (exec_req_i && non_dma_i && ph_q == PH_EXEC) begin
        irq_q <= 1'b1;
      end else if (xfer_evt || (res_evt && res_idx_q == 3'h0)) begin
        irq_q <= 1'b0;
      end
      if (exec_req_i && !non_dma_i && ph_q == PH_EXEC && !exec_stop) begin
        drq_q <= 1'b1;
      end else if ((xfer_evt && dma_acknowledge_eff) || exec_stop) begin
        drq_q <= 1'b0;
      end
      if (exec_req_i && !write_cmd_i) begin
        xbuf_q <= exec_rd_data_i;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cmd_byte_o <= 8'h00;
      cmd_strobe_o <= 1'b0;
      exec_wr_data_o <= 8'h00;
      exec_wr_valid_o <= 1'b0;
      tc_o <= 1'b0;
    end else begin
      cmd_strobe_o <= cmd_evt;
      exec_wr_valid_o <= xfer_evt && write_cmd_i;
      tc_o <= tc_hit;
      if (cmd_evt) begin
        cmd_byte_o <= wdata_q;
      end
      if (xfer_evt && write_cmd_i) begin
        exec_wr_data_o <= wdata_q;
      end
    end
  end

  // divider reloads only at a period end, so a rate change never glitches
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rate_q <= fdh_pkg::RATE_RESET;
      div_q <= 9'h001;
      bit_tick_o <= 1'b0;
    end else begin
      if (rate_wr_evt) begin
        rate_q <= wdata_q[1:0];
      end
      bit_tick_o <= (div_q == 9'h001);
      if (div_q == 9'h001) begin
        div_q <= div_for(rate_q, fm_i, drive_speed_select_i);
      end else begin
        div_q <= div_q - 9'h001;
      end
    end
  end

  assign rate_sel_o = rate_q;
  assign bus.dev_data = dout_q;
  assign bus.dev_data_oe = db_oe_q;
  assign bus.irq = irq_q;
  assign bus.irq_oe = irq_oe_q;
  assign bus.drq = drq_q;
  assign bus.drq_oe = drq_oe_q;
endmodule

//--- fdh_pkg.sv
package fdh_pkg;
  localparam int CLK_HZ = 50_000_000;
  // ready and direction come back within this many microseconds at 500 kbps
  localparam int READY_US = 12;
  localparam int READY_KBPS = 500;
  localparam logic [3:0] READY_BITS = 4'(READY_US * READY_KBPS / 1000);
  localparam logic [8:0] DIV_500K = 9'(CLK_HZ / 500_000);
  localparam logic [8:0] DIV_300K = 9'(CLK_HZ / 300_000);
  localparam logic [8:0] DIV_250K = 9'(CLK_HZ / 250_000);
  localparam logic [8:0] DIV_125K = 9'(CLK_HZ / 125_000);
  localparam logic [1:0] RATE_RESET = 2'h2;
  localparam int MSR_RQM = 7;
  localparam int MSR_DIO = 6;
  localparam int MSR_EXM = 5;
  localparam int MSR_CB = 4;
  localparam logic [1:0] ST0_ABNORMAL = 2'h1;
  localparam int RES_MAX = 7;
  // pin sample vector: rd, wr, cs, a0, rate_register_load_strobe, dma_acknowledge, tc, data
  localparam logic [14:0] SYNC_RESET = 15'h7600;
  localparam logic [3:0] STROBE_CYCLES = 4'h8;
  localparam logic [3:0] GAP_CYCLES = 4'h4;
  localparam logic [3:0] HOST_CTRL_OFS = 4'h0;
  localparam logic [3:0] HOST_STAT_OFS = 4'h4;
  localparam int CTRL_KIND_LSB = 8;
  localparam int CTRL_TC_BIT = 11;
  localparam int STAT_BUSY_BIT = 8;
  typedef enum logic [1:0] {
    FDH_MODE_BASE, FDH_MODE_SPECIAL, FDH_MODE_AT
  } fdh_mode_t;
  typedef enum logic [2:0] {
    FDH_KIND_STATUS, FDH_KIND_CMD_WR, FDH_KIND_RES_RD, FDH_KIND_PIO_RD,
    FDH_KIND_PIO_WR, FDH_KIND_DMA_RD, FDH_KIND_DMA_WR, FDH_KIND_RATE
  } fdh_kind_t;
endpackage

//--- fdh_bus_if.sv
`timescale 1ns/1ps
interface fdh_bus_if;
  logic cs_n;
  logic a0;
  logic rd_n;
  logic wr_n;
  logic rate_register_load_strobe_n;
  logic dma_acknowledge_n;
  logic tc;
  logic [7:0] host_data;
  logic host_data_oe;
  logic [7:0] dev_data;
  logic dev_data_oe;
  logic irq;
  logic irq_oe;
  logic drq;
  logic drq_oe;
  logic [7:0] db;
  logic irq_line;
  logic drq_line;
  // undriven data floats high, undriven request lines read low
  assign db = dev_data_oe ? dev_data : (host_data_oe ? host_data : 8'hFF);
  assign irq_line = irq_oe & irq;
  assign drq_line = drq_oe & drq;
  modport dev (input cs_n, a0, rd_n, wr_n, rate_register_load_strobe_n, dma_acknowledge_n, tc, db,
               output dev_data, dev_data_oe, irq, irq_oe, drq, drq_oe);
  modport host (output cs_n, a0, rd_n, wr_n, rate_register_load_strobe_n, dma_acknowledge_n, tc,
                host_data, host_data_oe, input db, irq_line, drq_line);
endinterface

//--- fdh_host.sv
`timescale 1ns/1ps
module fdh_host (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  fdh_bus_if.host bus,
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o
);
  typedef enum logic [2:0] {H_IDLE, H_SETUP, H_STROBE, H_HOLD, H_GAP}
    fdh_hstate_t;
  fdh_hstate_t st_q;
  fdh_pkg::fdh_kind_t kind_q;
  logic [9:0] s1_q, s2_q;
  logic [7:0] wdat_q, rdat_q;
  logic tcf_q, poll_q, busy_q, done_q, empty_q, wait_q;
  logic [3:0] cnt_q;
  logic cs_n_q, a0_q, rd_n_q, wr_n_q, rate_register_load_strobe_n_q, dma_acknowledge_n_q, tc_q, oe_q;

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s1_q <= 10'h000;
      s2_q <= 10'h000;
    end else begin
      s1_q <= {bus.irq_line, bus.drq_line, bus.db};
      s2_q <= s1_q;
    end
  end

  logic is_dma, is_rd, start;
  assign is_dma = kind_q == fdh_pkg::FDH_KIND_DMA_RD ||
                  kind_q == fdh_pkg::FDH_KIND_DMA_WR;
  assign is_rd = poll_q || kind_q == fdh_pkg::FDH_KIND_STATUS ||
                 kind_q == fdh_pkg::FDH_KIND_RES_RD ||
                 kind_q == fdh_pkg::FDH_KIND_PIO_RD ||
                 kind_q == fdh_pkg::FDH_KIND_DMA_RD;
  assign start = avs_write_i && !wait_q && !busy_q &&
                 avs_address_i == fdh_pkg::HOST_CTRL_OFS;

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wait_q <= 1'b1;
      avs_readdata_o <= 32'h0000_0000;
    end else begin
      wait_q <= !((avs_read_i || avs_write_i) && wait_q);
      if (avs_read_i && wait_q) begin
        if (avs_address_i == fdh_pkg::HOST_STAT_OFS) begin
          avs_readdata_o <= {19'h0, empty_q, s2_q[8], s2_q[9], done_q,
                             busy_q, rdat_q};
        end else begin
          avs_readdata_o <= 32'h0000_0000;
        end
      end
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_q <= H_IDLE;
      kind_q <= fdh_pkg::FDH_KIND_STATUS;
      wdat_q <= 8'h00;
      rdat_q <= 8'h00;
      tcf_q <= 1'b0;
      poll_q <= 1'b0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      empty_q <= 1'b0;
      cnt_q <= 4'h0;
      cs_n_q <= 1'b1;
      a0_q <= 1'b0;
      rd_n_q <= 1'b1;
      wr_n_q <= 1'b1;
      rate_register_load_strobe_n_q <= 1'b1;
      dma_acknowledge_n_q <= 1'b1;
      tc_q <= 1'b0;
      oe_q <= 1'b0;
    end else begin
      case (st_q)
        H_IDLE: begin
          if (start) begin
            kind_q <= fdh_pkg::fdh_kind_t'(
              avs_writedata_i[fdh_pkg::CTRL_KIND_LSB +: 3]);
            wdat_q <= avs_writedata_i[7:0];
            tcf_q <= avs_writedata_i[fdh_pkg::CTRL_TC_BIT];
            // status is polled before every command and result byte
            poll_q <= avs_writedata_i[fdh_pkg::CTRL_KIND_LSB +: 3] ==
                        fdh_pkg::FDH_KIND_CMD_WR ||
                      avs_writedata_i[fdh_pkg::CTRL_KIND_LSB +: 3] ==
                        fdh_pkg::FDH_KIND_RES_RD;
            busy_q <= 1'b1;
            done_q <= 1'b0;
            empty_q <= 1'b0;
            st_q <= H_SETUP;
          end
        end
        H_SETUP: begin
          cs_n_q <= is_dma || (kind_q == fdh_pkg::FDH_KIND_RATE &&
                    !poll_q);
          dma_acknowledge_n_q <= !(is_dma && !poll_q);
          rate_register_load_strobe_n_q <= !(kind_q == fdh_pkg::FDH_KIND_RATE);
          a0_q <= !(poll_q || kind_q == fdh_pkg::FDH_KIND_STATUS);
          oe_q <= !is_rd;
          cnt_q <= fdh_pkg::STROBE_CYCLES;
          st_q <= H_STROBE;
        end
        H_STROBE: begin
          rd_n_q <= !is_rd;
          wr_n_q <= is_rd;
          tc_q <= is_dma && tcf_q;
          cnt_q <= cnt_q - 4'h1;
          if (cnt_q == 4'h1) begin
            rdat_q <= s2_q[7:0];
            st_q <= H_HOLD;
          end
        end
        H_HOLD: begin
          rd_n_q <= 1'b1;
          wr_n_q <= 1'b1;
          tc_q <= 1'b0;
          cnt_q <= fdh_pkg::GAP_CYCLES;
          st_q <= H_GAP;
          if (poll_q) begin
            if (kind_q == fdh_pkg::FDH_KIND_CMD_WR) begin
              poll_q <= !(rdat_q[fdh_pkg::MSR_RQM] &&
                          !rdat_q[fdh_pkg::MSR_DIO]);
            end else if (rdat_q[fdh_pkg::MSR_RQM] &&
                         !rdat_q[fdh_pkg::MSR_DIO]) begin
              busy_q <= 1'b0;
              done_q <= 1'b1;
              empty_q <= 1'b1;
            end else begin
              poll_q <= !(rdat_q[fdh_pkg::MSR_RQM] &&
                          rdat_q[fdh_pkg::MSR_DIO]);
            end
          end else begin
            busy_q <= 1'b0;
            done_q <= 1'b1;
          end
        end
        default: begin
          cs_n_q <= 1'b1;
          dma_acknowledge_n_q <= 1'b1;
          rate_register_load_strobe_n_q <= 1'b1;
          oe_q <= 1'b0;
          cnt_q <= cnt_q - 4'h1;
          if (cnt_q == 4'h1) begin
            st_q <= busy_q ? H_SETUP : H_IDLE;
          end
        end
      endcase
    end
  end

  assign avs_waitrequest_o = wait_q;
  assign bus.cs_n = cs_n_q;
  assign bus.a0 = a0_q;
  assign bus.rd_n = rd_n_q;
  assign bus.wr_n = wr_n_q;
  assign bus.rate_register_load_strobe_n = rate_register_load_strobe_n_q;
  assign bus.dma_acknowledge_n = dma_acknowledge_n_q;
  assign bus.tc = tc_q;
  assign bus.host_data = wdat_q;
  assign bus.host_data_oe = oe_q;
endmodule

//--- fdh_bus_properties.sv
`timescale 1ns/1ps
module fdh_bus_properties (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic cs_n,
  input wire logic a0,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic rate_register_load_strobe_n,
  input wire logic dma_acknowledge_n,
  input wire logic host_data_oe,
  input wire logic dev_data_oe,
  input wire logic irq,
  input wire logic irq_oe,
  input wire logic drq,
  input wire logic drq_oe
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!reset_n_i);
  // both request pins sit behind the same gate
  oe_pair_a:
    assert property (irq_oe == drq_oe) else $error("request enables differ");
  no_clash_a:
    assert property (!(dev_data_oe && host_data_oe)) else $error("bus clash");
  read_drive_a:
    assert property (rd_n [*5] |-> !dev_data_oe)
    else $error("data driven without read");
  req_excl_a:
    assert property (!(irq && drq)) else $error("irq and drq together");
  // strobe trailing edges pass two sync flops before the device acts
  drq_clear_a:
    assert property (($rose(rd_n) || $rose(wr_n)) && !dma_acknowledge_n && drq
      |-> ##[2:4] !drq) else $error("drq not cleared by dma access");
  irq_rd_clear_a:
    assert property ($rose(rd_n) && !cs_n && a0 && irq |-> ##[2:4] !irq)
    else $error("irq not cleared by data read");
  irq_wr_clear_a:
    assert property ($rose(wr_n) && !cs_n && a0 && irq |-> ##[2:4] !irq)
    else $error("irq not cleared by data write");
  status_quiet_a:
    assert property ($rose(rd_n) && !cs_n && !a0 && irq |-> irq [*4])
    else $error("status read disturbed irq");
  strobe_gate_a:
    assert property (!rd_n || !wr_n |-> !cs_n || !dma_acknowledge_n || !rate_register_load_strobe_n)
    else $error("strobe without select");
  rate_quiet_a:
    assert property (!rate_register_load_strobe_n |-> !dev_data_oe)
    else $error("drive in rate load");
endmodule

//--- test_floppy_ctrl_host_port.sv
`timescale 1ns/1ps
module test_floppy_ctrl_host_port;
  logic mclk_i;
  logic reset_n_i;
  fdh_pkg::fdh_mode_t mode_i;
  logic dma_gate_enable_i, non_dma_i, fm_i, drive_speed_select_i;
  logic cmd_done_i, write_cmd_i, exec_req_i, exec_end_i;
  logic [3:0] seek_busy_i;
  logic [7:0] exec_rd_data_i, cmd_byte_o, exec_wr_data_o;
  logic [55:0] res_data_i;
  logic [2:0] res_count_i;
  logic cmd_strobe_o, exec_wr_valid_o, tc_o, bit_tick_o;
  logic [1:0] rate_sel_o;
  logic [3:0] avs_address_i;
  logic avs_read_i, avs_write_i, avs_waitrequest_o;
  logic [31:0] avs_writedata_i, avs_readdata_o;
  logic [7:0] last_cmd = 8'h00;
  logic [7:0] last_wr = 8'h00;
  logic tc_seen = 1'b0;
  int n_cmd = 0;
  int n_exp = 0;
  int n_errors = 0;
  int total_checks = 0;
  fdh_bus_if bus_if();
  fdh_device i_fdh_device (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
    .bus(bus_if), .mode_i(mode_i), .dma_gate_enable_i(dma_gate_enable_i),
    .non_dma_i(non_dma_i), .fm_i(fm_i),
    .drive_speed_select_i(drive_speed_select_i), .seek_busy_i(seek_busy_i),
    .cmd_byte_o(cmd_byte_o), .cmd_strobe_o(cmd_strobe_o),
    .cmd_done_i(cmd_done_i), .write_cmd_i(write_cmd_i),
    .exec_req_i(exec_req_i), .exec_rd_data_i(exec_rd_data_i),
    .exec_end_i(exec_end_i), .exec_wr_data_o(exec_wr_data_o),
    .exec_wr_valid_o(exec_wr_valid_o), .tc_o(tc_o),
    .res_data_i(res_data_i), .res_count_i(res_count_i),
    .rate_sel_o(rate_sel_o), .bit_tick_o(bit_tick_o));
  fdh_host i_fdh_host (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .bus(bus_if),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o));
  fdh_bus_properties i_fdh_bus_properties (.mclk_i(mclk_i),
    .reset_n_i(reset_n_i), .cs_n(bus_if.cs_n), .a0(bus_if.a0),
    .rd_n(bus_if.rd_n), .wr_n(bus_if.wr_n), .rate_register_load_strobe_n(bus_if.rate_register_load_strobe_n),
    .dma_acknowledge_n(bus_if.dma_acknowledge_n), .host_data_oe(bus_if.host_data_oe),
    .dev_data_oe(bus_if.dev_data_oe), .irq(bus_if.irq),
    .irq_oe(bus_if.irq_oe), .drq(bus_if.drq), .drq_oe(bus_if.drq_oe));

  initial begin
    mclk_i = 1'b0;
    forever #10 mclk_i = ~mclk_i;
  end

  // core-side capture, since strobes last a single cycle
  always @(posedge mclk_i) begin
    if (cmd_strobe_o === 1'b1) begin
      last_cmd <= cmd_byte_o;
      n_cmd <= n_cmd + 1;
    end
    if (exec_wr_valid_o === 1'b1) last_wr <= exec_wr_data_o;
    if (tc_o === 1'b1) tc_seen <= 1'b1;
  end

  task automatic report_and_stop();
    if (n_errors == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", n, exp, seen);
    end
  endtask

  task automatic av(input logic wr, input logic [3:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    @(posedge mclk_i);
    avs_address_i <= a;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    avs_writedata_i <= d;
    do @(posedge mclk_i); while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask

  // one controller order, then poll until the bus cycle is over
  task automatic op(input fdh_pkg::fdh_kind_t k, input logic [7:0] d,
                    input logic t, output logic [31:0] st);
    av(1'b1, fdh_pkg::HOST_CTRL_OFS, {20'h0, t, k, d}, st);
    do av(1'b0, fdh_pkg::HOST_STAT_OFS, 32'h0, st);
    while (st[fdh_pkg::STAT_BUSY_BIT] !== 1'b0);
    // the device acts three cycles after the strobe is released
    repeat (4) @(posedge mclk_i);
  endtask

  task automatic pulse(input int k);
    @(posedge mclk_i);
    case (k)
      0: cmd_done_i <= 1'b1;
      1: exec_req_i <= 1'b1;
      default: exec_end_i <= 1'b1;
    endcase
    @(posedge mclk_i);
    {cmd_done_i, exec_req_i, exec_end_i} <= 3'h0;
    repeat (2) @(posedge mclk_i);
  endtask

  task automatic start_cmd(input logic [7:0] code);
    logic [31:0] st;
    op(fdh_pkg::FDH_KIND_CMD_WR, code, 1'b0, st);
    n_exp++;
    chk("command byte", 32'(last_cmd), 32'(code));
    chk("command count", 32'(n_cmd), 32'(n_exp));
  endtask

  task automatic results(input int cnt, input logic [7:0] first);
    logic [31:0] st;
    for (int i = 0; i < cnt; i++) begin
      op(fdh_pkg::FDH_KIND_RES_RD, 8'h00, 1'b0, st);
      chk("result", 32'(st[7:0]),
          32'(i == 0 ? first : res_data_i[i*8+:8]));
      if (i == 0) chk("irq first result", 32'(bus_if.irq_line), 32'h0);
    end
    op(fdh_pkg::FDH_KIND_RES_RD, 8'h00, 1'b0, st);
    chk("result phase over", 32'(st[12]), 32'h1);
    // busy falls six bit times after the last result byte
    repeat (700) @(posedge mclk_i);
    op(fdh_pkg::FDH_KIND_STATUS, 8'h00, 1'b0, st);
    chk("idle status", 32'(st[7:0]), 32'h80);
  endtask

  // the first period after a switch may be stretched
  task automatic period(output int n);
    repeat (2) begin
      do @(posedge mclk_i); while (bit_tick_o !== 1'b1);
      n = 0;
      do begin
        @(posedge mclk_i);
        n++;
      end while (bit_tick_o !== 1'b1);
    end
  endtask

  initial begin
    logic [31:0] st;
    logic [8:0] div [4];
    int n;
    div = '{fdh_pkg::DIV_500K, fdh_pkg::DIV_300K, fdh_pkg::DIV_250K,
            fdh_pkg::DIV_125K};
    reset_n_i = 1'b0;
    mode_i = fdh_pkg::FDH_MODE_BASE;
    {dma_gate_enable_i, fm_i, write_cmd_i} = 3'h0;
    {non_dma_i, drive_speed_select_i} = 2'h3;
    {cmd_done_i, exec_req_i, exec_end_i} = 3'h0;
    seek_busy_i = 4'hA;
    exec_rd_data_i = 8'h00;
    res_data_i = 56'h77665544332211;
    res_count_i = 3'h7;
    {avs_read_i, avs_write_i, avs_address_i} = 6'h00;
    avs_writedata_i = 32'h0;
    repeat (3) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    chk("rate reset", 32'(rate_sel_o), 32'(fdh_pkg::RATE_RESET));
    av(1'b0, 4'h8, 32'h0, st);
    chk("unmapped read", st, 32'h0);
    repeat (2000) @(posedge mclk_i);
    op(fdh_pkg::FDH_KIND_STATUS, 8'h00, 1'b0, st);
    chk("reset status", 32'(st[7:0]), 32'h8A);
    seek_busy_i <= 4'h0;
    for (int c = 3; c >= 0; c--) begin
      op(fdh_pkg::FDH_KIND_RATE, 8'hFC | 8'(c), 1'b0, st);
      chk("rate select", 32'(rate_sel_o), 32'(c));
      period(n);
      chk("bit period", 32'(n), 32'(div[c]));
    end
    fm_i <= 1'b1;
    period(n);
    chk("fm period", 32'(n), 32'(fdh_pkg::DIV_250K));
    fm_i <= 1'b0;
    start_cmd(8'h46);
    start_cmd(8'h01);
    pulse(0);
    for (int b = 0; b < 2; b++) begin
      exec_rd_data_i <= b == 0 ? 8'hA5 : 8'h5A;
      pulse(1);
      chk("irq per byte", 32'(bus_if.irq_line), 32'h1);
      op(fdh_pkg::FDH_KIND_STATUS, 8'h00, 1'b0, st);
      chk("exec status", 32'(st[7:0]), 32'hF0);
      chk("irq in status", 32'(st[10]), 32'h1);
      chk("irq after status", 32'(bus_if.irq_line), 32'h1);
      op(fdh_pkg::FDH_KIND_PIO_RD, 8'h00, 1'b0, st);
      chk("pio byte", 32'(st[7:0]), 32'(exec_rd_data_i));
      chk("irq after read", 32'(bus_if.irq_line), 32'h0);
    end
    pulse(2);
    chk("irq at result", 32'(bus_if.irq_line), 32'h1);
    op(fdh_pkg::FDH_KIND_STATUS, 8'h00, 1'b0, st);
    chk("result status", 32'(st[6:4]), 32'h5);
    results(7, 8'h11);
    mode_i <= fdh_pkg::FDH_MODE_SPECIAL;
    {non_dma_i, write_cmd_i, res_count_i} <= 5'h09;
    start_cmd(8'h45);
    pulse(0);
    pulse(1);
    chk("drq gated off", 32'(bus_if.drq_line), 32'h0);
    dma_gate_enable_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    chk("drq per byte", 32'(bus_if.drq_line), 32'h1);
    chk("no dma irq", 32'(bus_if.irq_line), 32'h0);
    op(fdh_pkg::FDH_KIND_DMA_WR, 8'h3C, 1'b1, st);
    chk("dma byte", 32'(last_wr), 32'h3C);
    chk("terminal count", 32'(tc_seen), 32'h1);
    chk("drq cleared", 32'(bus_if.drq_line), 32'h0);
    chk("irq at count", 32'(bus_if.irq_line), 32'h1);
    results(1, 8'h11);
    mode_i <= fdh_pkg::FDH_MODE_AT;
    non_dma_i <= 1'b1;
    start_cmd(8'h45);
    pulse(0);
    pulse(1);
    op(fdh_pkg::FDH_KIND_PIO_WR, 8'hC3, 1'b0, st);
    chk("pio write", 32'(last_wr), 32'hC3);
    chk("irq after write", 32'(bus_if.irq_line), 32'h0);
    pulse(2);
    results(1, 8'h51);
    report_and_stop();
  end

  // the whole sequence needs roughly 15000 cycles
  initial begin
    repeat (90000) @(posedge mclk_i);
    n_errors++;
    report_and_stop();
  end
endmodule
